//--- src/timer_unit_pkg.sv
// Constants, register map and types shared by the timer unit
package timer_unit_pkg;

  // ****************************************************************
  // Register offsets (byte-wide registers)
  // ****************************************************************
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 8;
  localparam logic [4:0] OFF_CPU_MODE    = 5'h00;
  localparam logic [4:0] OFF_FIXED_PRE   = 5'h01;
  localparam logic [4:0] OFF_FIXED_TMR   = 5'h02;
  localparam logic [4:0] OFF_SEL_PRE     = 5'h03;
  localparam logic [4:0] OFF_SEL_TMR     = 5'h04;
  localparam logic [4:0] OFF_SEL_MODE    = 5'h05;
  localparam logic [4:0] OFF_SEL_SOURCE  = 5'h06;
  localparam logic [4:0] OFF_WIDE_SOURCE = 5'h07;
  localparam logic [4:0] OFF_WIDE_CTRL   = 5'h08;
  localparam logic [4:0] OFF_WIDE_A_LOW  = 5'h09;
  localparam logic [4:0] OFF_WIDE_A_HIGH = 5'h0A;
  localparam logic [4:0] OFF_WIDE_B_LOW  = 5'h0B;
  localparam logic [4:0] OFF_WIDE_B_HIGH = 5'h0C;
  localparam logic [4:0] OFF_IRQ_FLAGS   = 5'h0D;
  localparam logic [4:0] OFF_KEY_INPUTS  = 5'h0E;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned CLKDIV_HI    = 7;
  localparam int unsigned CLKDIV_LO    = 6;
  localparam logic [1:0]  CLKDIV_ONCHIP = 2'h2;
  localparam int unsigned MODE_HI      = 1;
  localparam int unsigned MODE_LO      = 0;
  localparam int unsigned EDGE_BIT     = 2;
  localparam int unsigned STOP_BIT     = 3;
  localparam int unsigned AUX_EN_BIT   = 4;
  localparam int unsigned SRC_A_HI     = 2;
  localparam int unsigned SRC_A_LO     = 0;
  localparam int unsigned SRC_B_HI     = 5;
  localparam int unsigned SRC_B_LO     = 3;
  localparam logic [2:0]  SRC_SPECIAL  = 3'h6;
  localparam int unsigned WA_LATCH_ONLY = 0;
  localparam int unsigned WB_LATCH_ONLY = 1;
  localparam int unsigned WA_STOP       = 2;
  localparam int unsigned WB_STOP       = 3;

  // Request flag bits
  localparam int unsigned IRQ_N     = 6;
  localparam int unsigned IRQ_KEY   = 0;
  localparam int unsigned IRQ_FIXED = 1;
  localparam int unsigned IRQ_SEL   = 2;
  localparam int unsigned IRQ_PIN   = 3;
  localparam int unsigned IRQ_WA    = 4;
  localparam int unsigned IRQ_WB    = 5;

  // ****************************************************************
  // Reset values and divider taps
  // ****************************************************************
  localparam logic [7:0]  RST_BYTE     = 8'hFF;
  localparam logic [15:0] RST_WORD     = 16'hFFFF;
  localparam logic [7:0]  RST_ZERO     = 8'h00;
  localparam logic [3:0]  FIXED_TAP    = 4'h4;

  typedef enum logic [1:0] {
    MODE_TIMER,
    MODE_PULSE,
    MODE_EVENT,
    MODE_WIDTH
  } sel_mode_t;

endpackage : timer_unit_pkg

//--- src/reload_counter.sv
// Reloadable down counter with a reload latch
`timescale 1ns/1ps
module reload_counter #(
  parameter int unsigned WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
  input  wire logic             mclk,
  input  wire logic             reset_n,
  input  wire logic             count_en,
  input  wire logic             write_both,
  input  wire logic             write_latch,
  input  wire logic [WIDTH-1:0] write_value,
  output logic      [WIDTH-1:0] count,
  output logic      [WIDTH-1:0] latch,
  output logic                  underflow
);

  // Count after zero is the underflow; ratio becomes 1/(n+1)
  assign underflow = count_en && (count == '0);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      latch <= RESET_VALUE;
    end else if (write_both || write_latch) begin
      latch <= write_value;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      count <= RESET_VALUE;
    end else if (write_both) begin
      count <= write_value;
    end else if (underflow) begin
      count <= latch;
    end else if (count_en) begin
      count <= count - 1'b1;
    end
  end

endmodule : reload_counter

//--- src/multi_timer_unit.sv
// Timer unit: fixed pair, mode-selectable pair, two wide timers, key wake-up
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/1ps
module multi_timer_unit
  import timer_unit_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic [7:0]        key_port,
  input  wire logic              onchip_osc_tick,
  input  wire logic              counter_pin_in,
  output logic                   counter_pin_out,
  output logic                   counter_pin_oe,
  output logic                   aux_timer_output_pin,
  output logic      [IRQ_N-1:0]  irq_flags
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic div_tap(input logic [7:0] div, input logic [3:0] taps);
    logic r;
    r = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if ((i < int'(taps)) && !div[i]) begin
        r = 1'b0;
      end
    end
    return r;
  endfunction : div_tap

  function automatic logic [3:0] src_taps(input logic [2:0] sel);
    logic [3:0] t;
    t = 4'h1;
    unique case (sel)
      3'h0:    t = 4'h1;
      3'h1:    t = 4'h4;
      3'h2:    t = 4'h5;
      3'h3:    t = 4'h6;
      3'h4:    t = 4'h7;
      default: t = 4'h8;
    endcase
    return t;
  endfunction : src_taps

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0]       cpu_mode_reg;
  logic [7:0]       sel_mode_reg;
  logic [1:0]       sel_source_reg;
  logic [7:0]       wide_source_reg;
  logic [3:0]       wide_ctrl_reg;
  logic [7:0]       key_inputs_reg;
  logic [7:0]       wa_low_hold_reg;
  logic [7:0]       wb_low_hold_reg;
  logic [7:0]       wa_snap_reg;
  logic [7:0]       wb_snap_reg;
  logic [7:0]       div_reg;
  logic             key_and_reg;
  logic             pin_prev_reg;
  logic             pulse_reg;
  logic [IRQ_N-1:0] irq_next;
  logic [7:0]       rdata_next;
  logic             pulse_next;

  logic wr_fixed_pre, wr_fixed_tmr, wr_sel_pre, wr_sel_tmr;
  logic wr_wa_high, wr_wb_high, wr_flags;
  assign wr_fixed_pre = reg_wr && (reg_addr == OFF_FIXED_PRE);
  assign wr_fixed_tmr = reg_wr && (reg_addr == OFF_FIXED_TMR);
  assign wr_sel_pre   = reg_wr && (reg_addr == OFF_SEL_PRE);
  assign wr_sel_tmr   = reg_wr && (reg_addr == OFF_SEL_TMR);
  assign wr_wa_high   = reg_wr && (reg_addr == OFF_WIDE_A_HIGH);
  assign wr_wb_high   = reg_wr && (reg_addr == OFF_WIDE_B_HIGH);
  assign wr_flags     = reg_wr && (reg_addr == OFF_IRQ_FLAGS);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_mode_reg    <= RST_ZERO;
      sel_mode_reg    <= RST_ZERO;
      sel_source_reg  <= 2'h0;
      wide_source_reg <= RST_ZERO;
      wide_ctrl_reg   <= 4'h0;
      key_inputs_reg  <= RST_ZERO;
    end else if (reg_wr) begin
      unique case (reg_addr)
        OFF_CPU_MODE:    cpu_mode_reg <= reg_wdata;
        OFF_SEL_MODE:    sel_mode_reg <= reg_wdata;
        OFF_SEL_SOURCE:  sel_source_reg <= reg_wdata[1:0];
        OFF_WIDE_SOURCE: wide_source_reg <= reg_wdata;
        OFF_WIDE_CTRL:   wide_ctrl_reg <= reg_wdata[3:0];
        OFF_KEY_INPUTS:  key_inputs_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Low byte waits here until the high byte write commits the word
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wa_low_hold_reg <= RST_BYTE;
      wb_low_hold_reg <= RST_BYTE;
    end else begin
      if (reg_wr && (reg_addr == OFF_WIDE_A_LOW)) begin
        wa_low_hold_reg <= reg_wdata;
      end
      if (reg_wr && (reg_addr == OFF_WIDE_B_LOW)) begin
        wb_low_hold_reg <= reg_wdata;
      end
    end
  end

  // ****************************************************************
  // Clock divider
  // ****************************************************************
  logic src_tick;
  assign src_tick = (cpu_mode_reg[CLKDIV_HI:CLKDIV_LO] == CLKDIV_ONCHIP)
                    ? onchip_osc_tick : 1'b1;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      div_reg <= RST_ZERO;
    end else if (src_tick) begin
      div_reg <= div_reg + 8'h01;
    end
  end

  // ****************************************************************
  // Fixed pair
  // ****************************************************************
  logic [7:0] fp_count, fp_latch, ft_count, ft_latch;
  logic       fp_uf, ft_uf, fp_en;
  assign fp_en = src_tick && div_tap(div_reg, FIXED_TAP);

  reload_counter #(.WIDTH(8), .RESET_VALUE(RST_BYTE)) u_fixed_prescaler (
    .mclk(mclk), .reset_n(reset_n), .count_en(fp_en),
    .write_both(wr_fixed_pre), .write_latch(1'b0), .write_value(reg_wdata),
    .count(fp_count), .latch(fp_latch), .underflow(fp_uf)
  );

  reload_counter #(.WIDTH(8), .RESET_VALUE(RST_BYTE)) u_fixed_timer (
    .mclk(mclk), .reset_n(reset_n), .count_en(fp_uf),
    .write_both(wr_fixed_tmr), .write_latch(1'b0), .write_value(reg_wdata),
    .count(ft_count), .latch(ft_latch), .underflow(ft_uf)
  );

  // ****************************************************************
  // Mode-selectable pair
  // ****************************************************************
  sel_mode_t  sel_mode;
  logic       edge_sel, sel_stop, pin_rise, pin_fall, sel_src, sp_en, sp_uf, st_uf;
  logic [7:0] sp_count, sp_latch, st_count, st_latch;
  assign sel_mode = sel_mode_t'(sel_mode_reg[MODE_HI:MODE_LO]);
  assign edge_sel = sel_mode_reg[EDGE_BIT];
  assign sel_stop = sel_mode_reg[STOP_BIT];
  assign pin_rise = counter_pin_in && !pin_prev_reg;
  assign pin_fall = !counter_pin_in && pin_prev_reg;

  always_comb begin
    sel_src = src_tick && div_tap(div_reg, src_taps({1'b0, sel_source_reg}));
    unique case (sel_mode)
      MODE_EVENT: sel_src = edge_sel ? pin_fall : pin_rise;
      MODE_WIDTH: sel_src = sel_src && (counter_pin_in != edge_sel);
      MODE_TIMER, MODE_PULSE: ;
    endcase
  end
  assign sp_en = sel_src && !sel_stop;

  reload_counter #(.WIDTH(8), .RESET_VALUE(RST_BYTE)) u_select_prescaler (
    .mclk(mclk), .reset_n(reset_n), .count_en(sp_en),
    .write_both(wr_sel_pre), .write_latch(1'b0), .write_value(reg_wdata),
    .count(sp_count), .latch(sp_latch), .underflow(sp_uf)
  );

  reload_counter #(.WIDTH(8), .RESET_VALUE(RST_BYTE)) u_select_timer (
    .mclk(mclk), .reset_n(reset_n), .count_en(sp_uf && !sel_stop),
    .write_both(wr_sel_tmr), .write_latch(1'b0), .write_value(reg_wdata),
    .count(st_count), .latch(st_latch), .underflow(st_uf)
  );

  // Outside pulse mode the level is preset to its starting value
  always_comb begin
    if (sel_mode != MODE_PULSE) begin
      pulse_next = !edge_sel;
    end else if (st_uf) begin
      pulse_next = !pulse_reg;
    end else begin
      pulse_next = pulse_reg;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pulse_reg            <= 1'b1;
      counter_pin_out      <= 1'b1;
      counter_pin_oe       <= 1'b0;
      aux_timer_output_pin <= 1'b0;
      pin_prev_reg         <= 1'b0;
    end else begin
      pulse_reg            <= pulse_next;
      counter_pin_out      <= pulse_next;
      counter_pin_oe       <= (sel_mode == MODE_PULSE);
      aux_timer_output_pin <= sel_mode_reg[AUX_EN_BIT] && !pulse_next;
      pin_prev_reg         <= counter_pin_in;
    end
  end

  // ****************************************************************
  // Wide timers
  // ****************************************************************
  logic [2:0]  wa_sel, wb_sel;
  logic        wa_tick, wb_tick, wa_uf, wb_uf;
  logic [15:0] wa_count, wa_latch, wb_count, wb_latch;
  assign wa_sel  = wide_source_reg[SRC_A_HI:SRC_A_LO];
  assign wb_sel  = wide_source_reg[SRC_B_HI:SRC_B_LO];
  assign wa_tick = (wa_sel >= SRC_SPECIAL) ? onchip_osc_tick
                   : (src_tick && div_tap(div_reg, src_taps(wa_sel)));
  assign wb_tick = (wb_sel >= SRC_SPECIAL) ? wa_uf
                   : (src_tick && div_tap(div_reg, src_taps(wb_sel)));

  reload_counter #(.WIDTH(16), .RESET_VALUE(RST_WORD)) u_wide_timer_a (
    .mclk(mclk), .reset_n(reset_n), .count_en(wa_tick && !wide_ctrl_reg[WA_STOP]),
    .write_both(wr_wa_high && !wide_ctrl_reg[WA_LATCH_ONLY]),
    .write_latch(wr_wa_high && wide_ctrl_reg[WA_LATCH_ONLY]),
    .write_value({reg_wdata, wa_low_hold_reg}),
    .count(wa_count), .latch(wa_latch), .underflow(wa_uf)
  );

  reload_counter #(.WIDTH(16), .RESET_VALUE(RST_WORD)) u_wide_timer_b (
    .mclk(mclk), .reset_n(reset_n), .count_en(wb_tick && !wide_ctrl_reg[WB_STOP]),
    .write_both(wr_wb_high && !wide_ctrl_reg[WB_LATCH_ONLY]),
    .write_latch(wr_wb_high && wide_ctrl_reg[WB_LATCH_ONLY]),
    .write_value({reg_wdata, wb_low_hold_reg}),
    .count(wb_count), .latch(wb_latch), .underflow(wb_uf)
  );

  // ****************************************************************
  // Key wake-up and request flags
  // ****************************************************************
  logic key_and;
  assign key_and = &(key_port | ~key_inputs_reg);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      key_and_reg <= 1'b1;
    end else begin
      key_and_reg <= key_and;
    end
  end

  // Writing 0 clears a flag; a new event in the same cycle wins
  always_comb begin
    irq_next = irq_flags;
    if (wr_flags) begin
      irq_next = irq_flags & reg_wdata[IRQ_N-1:0];
    end
    if (key_and_reg && !key_and) irq_next[IRQ_KEY] = 1'b1;
    if (ft_uf) irq_next[IRQ_FIXED] = 1'b1;
    if (st_uf) irq_next[IRQ_SEL] = 1'b1;
    if (edge_sel ? pin_rise : pin_fall) irq_next[IRQ_PIN] = 1'b1;
    if (wa_uf) irq_next[IRQ_WA] = 1'b1;
    if (wb_uf) irq_next[IRQ_WB] = 1'b1;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irq_flags <= '0;
    end else begin
      irq_flags <= irq_next;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  always_comb begin
    rdata_next = RST_ZERO;
    unique case (reg_addr)
      OFF_CPU_MODE:    rdata_next = cpu_mode_reg;
      OFF_FIXED_PRE:   rdata_next = fp_count;
      OFF_FIXED_TMR:   rdata_next = ft_count;
      OFF_SEL_PRE:     rdata_next = sp_count;
      OFF_SEL_TMR:     rdata_next = st_count;
      OFF_SEL_MODE:    rdata_next = sel_mode_reg;
      OFF_SEL_SOURCE:  rdata_next = {6'h00, sel_source_reg};
      OFF_WIDE_SOURCE: rdata_next = wide_source_reg;
      OFF_WIDE_CTRL:   rdata_next = {4'h0, wide_ctrl_reg};
      OFF_WIDE_A_LOW:  rdata_next = wa_snap_reg;
      OFF_WIDE_A_HIGH: rdata_next = wa_count[15:8];
      OFF_WIDE_B_LOW:  rdata_next = wb_snap_reg;
      OFF_WIDE_B_HIGH: rdata_next = wb_count[15:8];
      OFF_IRQ_FLAGS:   rdata_next = {2'b00, irq_flags};
      OFF_KEY_INPUTS:  rdata_next = key_inputs_reg;
      default:         rdata_next = RST_ZERO;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata   <= RST_ZERO;
      wa_snap_reg <= RST_BYTE;
      wb_snap_reg <= RST_BYTE;
    end else begin
      reg_rdata <= reg_rd ? rdata_next : RST_ZERO;
      if (reg_rd && (reg_addr == OFF_WIDE_A_HIGH)) begin
        wa_snap_reg <= wa_count[7:0];
      end
      if (reg_rd && (reg_addr == OFF_WIDE_B_HIGH)) begin
        wb_snap_reg <= wb_count[7:0];
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  property p_key_request;
    (key_and_reg && !key_and) |=> irq_flags[IRQ_KEY];
  endproperty
  a_key_request: assert property (p_key_request) else $error("key request lost");

  property p_fixed_reload;
    (fp_uf && !wr_fixed_pre) |=> (fp_count == $past(fp_latch));
  endproperty
  a_fixed_reload: assert property (p_fixed_reload) else $error("no reload");

  property p_fixed_flag;
    ft_uf |=> irq_flags[IRQ_FIXED];
  endproperty
  a_fixed_flag: assert property (p_fixed_flag) else $error("fixed flag missing");

  property p_fixed_step;
    (!fp_uf && !wr_fixed_tmr) |=> $stable(ft_count);
  endproperty
  a_fixed_step: assert property (p_fixed_step) else $error("fixed timer moved");

  property p_write_both;
    wr_fixed_tmr |=> (ft_count == $past(reg_wdata)) && (ft_latch == $past(reg_wdata));
  endproperty
  a_write_both: assert property (p_write_both) else $error("write not loaded");

  property p_read_count;
    (reg_rd && (reg_addr == OFF_SEL_TMR)) |=> (reg_rdata == $past(st_count));
  endproperty
  a_read_count: assert property (p_read_count) else $error("read not count");

  property p_pulse_toggle;
    (st_uf && (sel_mode == MODE_PULSE)) |=> (counter_pin_out != $past(counter_pin_out));
  endproperty
  a_pulse_toggle: assert property (p_pulse_toggle) else $error("no toggle");

  property p_aux_inverse;
    $past(sel_mode_reg[AUX_EN_BIT]) |-> (aux_timer_output_pin == !counter_pin_out);
  endproperty
  a_aux_inverse: assert property (p_aux_inverse) else $error("aux not inverse");

  property p_stop_holds;
    (sel_stop && !wr_sel_tmr && !wr_sel_pre) |=> $stable(st_count) && $stable(sp_count);
  endproperty
  a_stop_holds: assert property (p_stop_holds) else $error("stopped timer moved");

  property p_pin_request;
    (!edge_sel && pin_fall) |=> irq_flags[IRQ_PIN];
  endproperty
  a_pin_request: assert property (p_pin_request) else $error("pin request lost");

  sequence s_low_write;
    reg_wr && (reg_addr == OFF_WIDE_A_LOW);
  endsequence
  sequence s_high_write;
    wr_wa_high && !wide_ctrl_reg[WA_LATCH_ONLY];
  endsequence
  property p_word_commit;
    (s_low_write ##[1:3] s_high_write) |=>
      (wa_count == wa_latch) && (wa_count[7:0] == wa_low_hold_reg);
  endproperty
  a_word_commit: assert property (p_word_commit) else $error("word not committed");

  property p_latch_only;
    (wr_wa_high && wide_ctrl_reg[WA_LATCH_ONLY] && wide_ctrl_reg[WA_STOP]) |=>
      $stable(wa_count);
  endproperty
  a_latch_only: assert property (p_latch_only) else $error("counter touched");

endmodule : multi_timer_unit

//--- tb/pin_partner.sv
// Far-side model: counter pin wire, key pins and on-chip oscillator ticks
`timescale 1ns/1ps
module pin_partner #(
  parameter int unsigned TICK_DIV = 4
) (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       pin_level,
  input  wire logic [7:0] key_level,
  input  wire logic       pin_out,
  input  wire logic       pin_oe,
  output logic            tick,
  output logic            pin_in,
  output logic      [7:0] key_port
);
  logic [7:0] tick_reg;
  // Device drive wins on the shared counter pin while enabled
  assign pin_in = pin_oe ? pin_out : pin_level;
  assign tick   = (tick_reg == 8'h00);
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tick_reg <= 8'h00;
      key_port <= 8'hFF;
    end else begin
      tick_reg <= (tick_reg == 8'(TICK_DIV - 1)) ? 8'h00 : tick_reg + 8'h01;
      key_port <= key_level;
    end
  end
endmodule : pin_partner

//--- tb/multi_timer_unit_keywake_bench.sv
// Register-level testbench for the timer unit
`timescale 1ns/1ps
module multi_timer_unit_keywake_bench
  import timer_unit_pkg::*;
;
  logic              mclk, reset_n, reg_wr, reg_rd, pin_level, tick, pin_in, pin_out, pin_oe, aux;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic [7:0]        key_level, key_port;
  logic [IRQ_N-1:0]  irq_flags;
  logic [6:0]        watch;
  int                fails, checked;
  time               t1;
  assign watch = {pin_out, irq_flags};
  multi_timer_unit DUT (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .key_port(key_port), .onchip_osc_tick(tick), .counter_pin_in(pin_in),
    .counter_pin_out(pin_out), .counter_pin_oe(pin_oe), .aux_timer_output_pin(aux),
    .irq_flags(irq_flags));
  pin_partner #(.TICK_DIV(4)) partner (.mclk(mclk), .reset_n(reset_n), .pin_level(pin_level),
    .key_level(key_level), .pin_out(pin_out), .pin_oe(pin_oe), .tick(tick),
    .pin_in(pin_in), .key_port(key_port));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic results();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk({8'h00, reg_rdata}, {8'h00, exp});
  endtask : rd
  task automatic wait_bit(input int idx, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (watch[idx] !== 1'b1 && n < lim);
    if (watch[idx] !== 1'b1) begin
      fails++;
      $display("mismatch at %0t: wait ran out", $time);
      results();
    end
  endtask : wait_bit
  task automatic pulse();
    @(posedge mclk) pin_level <= 1'b1;
    repeat (4) @(posedge mclk);
    pin_level <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask : pulse
  task automatic period(input int exp);
    wr(OFF_IRQ_FLAGS, 8'h00);
    wait_bit(IRQ_FIXED, 200);
    // First wait only aligns; a set may coincide with that clear
    wr(OFF_IRQ_FLAGS, 8'h00);
    wait_bit(IRQ_FIXED, 200);
    t1 = $time;
    wr(OFF_IRQ_FLAGS, 8'h00);
    wait_bit(IRQ_FIXED, 200);
    chk(16'(($time - t1) / 10), 16'(exp));
  endtask : period
  initial begin
    reset_n   = 1'b0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 5'h00;
    reg_wdata = 8'h00;
    pin_level = 1'b0;
    key_level = 8'hFF;
    fails     = 0;
    checked   = 0;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    rd(OFF_SEL_MODE, 8'h00);
    rd(OFF_IRQ_FLAGS, 8'h00);
    rd(OFF_SEL_TMR, 8'hFF);
    rd(5'h1F, 8'h00);
    wr(OFF_SEL_MODE, 8'h08);
    wr(OFF_SEL_PRE, 8'h03);
    rd(OFF_SEL_PRE, 8'h03);
    repeat (20) @(posedge mclk);
    rd(OFF_SEL_PRE, 8'h03);
    wr(OFF_SEL_MODE, 8'h02);
    wr(OFF_SEL_TMR, 8'h02);
    wr(OFF_SEL_PRE, 8'h00);
    wr(OFF_IRQ_FLAGS, 8'h00);
    pulse();
    rd(OFF_SEL_TMR, 8'h01);
    pulse();
    chk(irq_flags[IRQ_SEL], 1'b0);
    pulse();
    chk(irq_flags[IRQ_SEL], 1'b1);
    chk(irq_flags[IRQ_PIN], 1'b1);
    wr(OFF_SEL_MODE, 8'h03);
    wr(OFF_SEL_TMR, 8'h05);
    wr(OFF_IRQ_FLAGS, 8'h00);
    repeat (30) @(posedge mclk);
    rd(OFF_SEL_TMR, 8'h05);
    pin_level <= 1'b1;
    wait_bit(IRQ_SEL, 100);
    wr(OFF_SEL_MODE, 8'h19);
    repeat (3) @(posedge mclk);
    #1;
    chk({pin_oe, pin_out, aux}, 3'b110);
    wr(OFF_SEL_MODE, 8'h1C);
    wr(OFF_SEL_MODE, 8'h1D);
    repeat (3) @(posedge mclk);
    #1;
    chk({pin_oe, pin_out, aux}, 3'b101);
    wr(OFF_SEL_MODE, 8'h15);
    wait_bit(6, 50);
    chk(aux, 1'b0);
    wr(OFF_WIDE_CTRL, 8'h0C);
    wr(OFF_WIDE_A_LOW, 8'hFF);
    wr(OFF_WIDE_A_HIGH, 8'hFF);
    wr(OFF_WIDE_CTRL, 8'h0F);
    wr(OFF_WIDE_A_LOW, 8'h34);
    wr(OFF_WIDE_A_HIGH, 8'h12);
    rd(OFF_WIDE_A_HIGH, 8'hFF);
    rd(OFF_WIDE_A_LOW, 8'hFF);
    wr(OFF_WIDE_CTRL, 8'h0C);
    wr(OFF_WIDE_A_LOW, 8'h34);
    rd(OFF_WIDE_A_HIGH, 8'hFF);
    rd(OFF_WIDE_A_LOW, 8'hFF);
    wr(OFF_WIDE_A_HIGH, 8'h12);
    rd(OFF_WIDE_A_HIGH, 8'h12);
    rd(OFF_WIDE_A_LOW, 8'h34);
    wr(OFF_WIDE_A_LOW, 8'h01);
    wr(OFF_WIDE_A_HIGH, 8'h00);
    wr(OFF_WIDE_B_LOW, 8'h00);
    wr(OFF_WIDE_B_HIGH, 8'h00);
    wr(OFF_WIDE_SOURCE, 8'h30);
    wr(OFF_IRQ_FLAGS, 8'h00);
    wr(OFF_WIDE_CTRL, 8'h00);
    wait_bit(IRQ_WA, 20);
    wait_bit(IRQ_WB, 20);
    wr(OFF_KEY_INPUTS, 8'h0F);
    wr(OFF_IRQ_FLAGS, 8'h00);
    key_level <= 8'hDF;
    repeat (5) @(posedge mclk);
    #1;
    chk(irq_flags[IRQ_KEY], 1'b0);
    key_level <= 8'hDB;
    wait_bit(IRQ_KEY, 10);
    wr(OFF_FIXED_PRE, 8'h00);
    wr(OFF_FIXED_TMR, 8'h00);
    period(16);
    wr(OFF_CPU_MODE, 8'h80);
    period(64);
    results();
  end
endmodule : multi_timer_unit_keywake_bench
